/* hw/fmr_pkg.sv */
// Shared constants and types for both ends of the serial memory read path.
// Assumes a single 125 MHz system clock for both ends and an open-drain two-wire bus.
//
// Overview of operation
// - Current read takes low address from latch.
// - Master sets read bit to request reads.
// - Read address is block bits plus latch.
// - Device drives data from clock after acknowledge.
// - Address counter increments after every read byte.
// - Master acknowledge makes device send next byte.
// - Unterminated read keeps device driving data.
// - Preferred end: no-acknowledge, then STOP.
// - Alternative end: no-acknowledge, then START.
// - STOP in acknowledge slot ends the read.
// - START in acknowledge slot ends, restarts.
// - Address wraps from top to zero.
// - Selective read opens with a write address.
// - Word address byte loads the address latch.
// - Repeated START abandons write, reads loaded address.
// - Address byte: block in 3..1, direction bit 0.
// - Every byte travels most significant bit first.
// - STOP aborts any operation in progress.
package fmr_pkg;

	// Clock and bus timing; a quarter of the bus period is a least time.
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCL_PERIOD_NS = 1000;
	localparam int QTR_NS        = SCL_PERIOD_NS / 4;
	localparam int QTR_CYC       = (QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);
	localparam logic [1:0] Q_SAMPLE = 2'h2;
	localparam logic [1:0] Q_END    = 2'h3;

	// Address byte layout; the device type value is arbitrary.
	localparam logic [3:0] DEV_TYPE = 4'h5;
	localparam int RW_POS  = 0;
	localparam int BLK_LO  = 1;
	localparam int BLK_HI  = 3;
	localparam int TYPE_LO = 4;
	localparam int TYPE_HI = 7;
	localparam int ADDR_W  = 11;
	localparam int LOW_W   = 8;

	// Bit counts within a byte slot.
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] BIT_MSB  = 4'h7;
	localparam logic [3:0] BIT_ONE  = 4'h1;
	localparam logic [3:0] BIT_NONE = 4'h0;

	// Ways the master ends a read.
	typedef enum logic [1:0] {
		END_NACK_STOP  = 2'h0,
		END_NACK_START = 2'h1,
		END_STOP9      = 2'h2,
		END_START9     = 2'h3
	} fmr_end_t;

	// Device states.
	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_ADDR = 3'h1,
		D_AACK = 3'h3,
		D_RD   = 3'h2,
		D_RACK = 3'h6,
		D_WADR = 3'h7,
		D_WACK = 3'h5,
		D_IGN  = 3'h4
	} fmr_dst_t;

	// Master states.
	typedef enum logic [2:0] {
		M_IDLE  = 3'h0,
		M_START = 3'h1,
		M_ADDR  = 3'h3,
		M_WADR  = 3'h2,
		M_READ  = 3'h6,
		M_RST   = 3'h7,
		M_STOP  = 3'h4
	} fmr_mst_t;

endpackage : fmr_pkg

/* hw/fmr_if.sv */
// Two-wire bus joining the master end and the memory end.
// Assumes open-drain wires with pull-ups: an enabled low output pulls the line low.
`timescale 1ns/100ps
`default_nettype none
interface fmr_if;

	// Driver signals of each end.
	logic scl_o;
	logic scl_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_d_o;
	logic sda_d_oe;

	// Resolved wire levels; a released wire reads high.
	logic scl;
	logic sda;
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_d_oe & ~sda_d_o));

	modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
		input scl, input sda);
	modport device (output sda_d_o, output sda_d_oe, input scl, input sda);

endinterface : fmr_if
`default_nettype wire

/* hw/fmr_dev.sv */
// Memory end of the serial read path: address byte, word address, read stream.
// Assumes bus levels synchronous to sys_clk and a byte store answering mem_addr_q.
`timescale 1ns/100ps
`default_nettype none
module fmr_dev (
	// Clock and reset.
	input  wire logic                          sys_clk,
	input  wire logic                          rst,
	// Serial bus.
	fmr_if.device                              bus,
	// Byte store read port.
	output logic [fmr_pkg::ADDR_W-1:0]         mem_addr_q,
	output logic                               rd_stb_q,
	input  wire logic [7:0]                    mem_data,
	// Status.
	output logic                               reading_q
);

	////////////////////////////////////////////////////////////////////////////////
	// Bus sampling and condition detection.

	logic scl_s_q;
	logic sda_s_q;
	logic scl_p_q;
	logic sda_p_q;
	logic rise;
	logic fall;
	logic start_ev;
	logic stop_ev;

	// One stage of sampling plus a previous copy for edges.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scl_s_q <= 1'b1;
			sda_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_s_q <= bus.scl;
			sda_s_q <= bus.sda;
			scl_p_q <= scl_s_q;
			sda_p_q <= sda_s_q;
		end
	end

	// Data moves only while the clock is low, so a data edge with the clock high is a condition.
	assign rise     = scl_s_q & ~scl_p_q;
	assign fall     = ~scl_s_q & scl_p_q;
	assign start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop_ev  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

	////////////////////////////////////////////////////////////////////////////////
	// Protocol state.

	fmr_pkg::fmr_dst_t         st_q;
	fmr_pkg::fmr_dst_t         st_d;
	logic [3:0]                cnt_q;
	logic [3:0]                cnt_d;
	logic [7:0]                sr_q;
	logic [7:0]                sr_d;
	logic                      rw_q;
	logic                      rw_d;
	logic                      ack_q;
	logic                      ack_d;
	logic                      oe_q;
	logic                      oe_d;
	logic [fmr_pkg::ADDR_W-1:0] addr_d;
	logic                      stb_d;
	logic                      rdg_d;
	logic                      sdo_q;

	// Next-state logic; STOP and START outrank every byte-level event.
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		sr_d   = sr_q;
		rw_d   = rw_q;
		ack_d  = ack_q;
		oe_d   = oe_q;
		addr_d = mem_addr_q;
		stb_d  = 1'b0;
		if (stop_ev) begin
			st_d = fmr_pkg::D_IDLE;
			oe_d = 1'b0;
		end else if (start_ev) begin
			st_d  = fmr_pkg::D_ADDR;
			cnt_d = fmr_pkg::BIT_NONE;
			oe_d  = 1'b0;
		end else begin
			case (st_q)
				fmr_pkg::D_ADDR, fmr_pkg::D_WADR: begin
					if (rise) begin
						sr_d  = {sr_q[6:0], sda_s_q};
						cnt_d = cnt_q + fmr_pkg::BIT_ONE;
					end else if (fall && cnt_q == fmr_pkg::BIT_LAST) begin
						if (st_q == fmr_pkg::D_WADR) begin
							st_d = fmr_pkg::D_WACK;
							oe_d = 1'b1;
							addr_d[fmr_pkg::LOW_W-1:0] = sr_q;
						end else if (sr_q[fmr_pkg::TYPE_HI:fmr_pkg::TYPE_LO] ==
								fmr_pkg::DEV_TYPE) begin
							st_d = fmr_pkg::D_AACK;
							oe_d = 1'b1;
							rw_d = sr_q[fmr_pkg::RW_POS];
							// Block bits land before any fetch.
							addr_d[fmr_pkg::ADDR_W-1:fmr_pkg::LOW_W] =
								sr_q[fmr_pkg::BLK_HI:fmr_pkg::BLK_LO];
						end else begin
							st_d = fmr_pkg::D_IGN;
						end
					end
				end
				fmr_pkg::D_AACK: begin
					if (fall) begin
						if (rw_q) begin
							// Low bits stay as the latch holds them.
							st_d  = fmr_pkg::D_RD;
							sr_d  = mem_data;
							oe_d  = ~mem_data[7];
							cnt_d = fmr_pkg::BIT_ONE;
							stb_d = 1'b1;
						end else begin
							st_d  = fmr_pkg::D_WADR;
							cnt_d = fmr_pkg::BIT_NONE;
							oe_d  = 1'b0;
						end
					end
				end
				fmr_pkg::D_RD: begin
					if (fall) begin
						if (cnt_q == fmr_pkg::BIT_LAST) begin
							// Count moves before the acknowledge slot.
							st_d   = fmr_pkg::D_RACK;
							oe_d   = 1'b0;
							addr_d = mem_addr_q + 11'h001;
						end else begin
							sr_d  = {sr_q[6:0], 1'b0};
							oe_d  = ~sr_q[6];
							cnt_d = cnt_q + fmr_pkg::BIT_ONE;
						end
					end
				end
				fmr_pkg::D_RACK: begin
					if (rise) begin
						ack_d = ~sda_s_q;
					end else if (fall) begin
						if (ack_q) begin
							// No STOP follows an acknowledge, so the stream runs on.
							st_d  = fmr_pkg::D_RD;
							sr_d  = mem_data;
							oe_d  = ~mem_data[7];
							cnt_d = fmr_pkg::BIT_ONE;
							stb_d = 1'b1;
						end else begin
							st_d = fmr_pkg::D_IGN;
						end
					end
				end
				fmr_pkg::D_WACK: begin
					// Write data is not handled; wait for the repeated START.
					if (fall) begin
						st_d = fmr_pkg::D_IGN;
						oe_d = 1'b0;
					end
				end
				fmr_pkg::D_IDLE, fmr_pkg::D_IGN: begin
					oe_d = 1'b0;
				end
				default: begin
					st_d = fmr_pkg::D_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
		rdg_d = (st_d == fmr_pkg::D_RD) || (st_d == fmr_pkg::D_RACK);
	end

	// State registers.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q       <= fmr_pkg::D_IDLE;
			cnt_q      <= fmr_pkg::BIT_NONE;
			sr_q       <= 8'h00;
			rw_q       <= 1'b0;
			ack_q      <= 1'b0;
			oe_q       <= 1'b0;
			mem_addr_q <= 11'h000;
			rd_stb_q   <= 1'b0;
			reading_q  <= 1'b0;
			sdo_q      <= 1'b0;
		end else begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			sr_q       <= sr_d;
			rw_q       <= rw_d;
			ack_q      <= ack_d;
			oe_q       <= oe_d;
			mem_addr_q <= addr_d;
			rd_stb_q   <= stb_d;
			reading_q  <= rdg_d;
			sdo_q      <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus drive.

	// Open drain: the output value is always low and the enable pulls the line.
	assign bus.sda_d_o  = sdo_q;
	assign bus.sda_d_oe = oe_q;

endmodule : fmr_dev
`default_nettype wire

/* hw/fmr_mst.sv */
// Master end of the serial read path: current, sequential and selective reads.
// Assumes a single-request user port sampled while idle and an open-drain bus.
`timescale 1ns/100ps
`default_nettype none
module fmr_mst (
	// Clock and reset.
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// Serial bus.
	fmr_if.master                  bus,
	// Request.
	input  wire logic              go,
	input  wire logic              sel,
	input  wire logic [2:0]        blk,
	input  wire logic [7:0]        waddr,
	input  wire logic [7:0]        nbyte,
	input  wire fmr_pkg::fmr_end_t mode,
	// Answer.
	output logic                   busy_q,
	output logic [7:0]             rx_q,
	output logic                   rx_vld_q,
	output logic                   done_q,
	output logic                   nack_q
);

	fmr_pkg::fmr_mst_t st_q;
	fmr_pkg::fmr_mst_t st_d;
	logic [5:0]        div_q;
	logic [5:0]        div_d;
	logic [1:0]        qtr_q;
	logic [1:0]        qtr_d;
	logic [3:0]        cnt_q;
	logic [3:0]        cnt_d;
	logic [7:0]        tx_q;
	logic [7:0]        tx_d;
	logic [7:0]        rsh_q;
	logic [7:0]        rsh_d;
	logic [7:0]        left_q;
	logic [7:0]        left_d;
	logic              sel_q;
	logic              sel_d;
	logic              wdone_q;
	logic              wdone_d;
	logic [2:0]        blk_q;
	logic [2:0]        blk_d;
	logic [7:0]        wa_q;
	logic [7:0]        wa_d;
	fmr_pkg::fmr_end_t mode_q;
	fmr_pkg::fmr_end_t mode_d;
	logic [7:0]        rx_d;
	logic              vld_d;
	logic              done_d;
	logic              nack_d;
	logic              busy_d;
	logic              scl_lv;
	logic              sda_lv;
	logic              tick;
	logic              slot_end;
	logic              more;
	logic              rw;
	logic              scl_oe_q;
	logic              sda_oe_q;

	////////////////////////////////////////////////////////////////////////////////
	// Slot levels: every slot is four quarters of the bus period.

	assign tick     = (div_q == fmr_pkg::QTR_LAST);
	assign slot_end = tick && (qtr_q == fmr_pkg::Q_END);
	assign more     = (left_q != 8'h00);
	assign rw       = ~(sel_q & ~wdone_q);

	// START drops data with clock high; STOP raises it with clock high.
	always_comb begin
		scl_lv = 1'b1;
		sda_lv = 1'b1;
		case (st_q)
			fmr_pkg::M_START, fmr_pkg::M_RST: begin
				scl_lv = qtr_q[0] ^ qtr_q[1];
				sda_lv = ~qtr_q[1];
			end
			fmr_pkg::M_STOP: begin
				scl_lv = (qtr_q != 2'h0);
				sda_lv = qtr_q[1];
			end
			fmr_pkg::M_ADDR, fmr_pkg::M_WADR: begin
				scl_lv = qtr_q[1];
				sda_lv = cnt_q[3] | tx_q[7];
			end
			fmr_pkg::M_READ: begin
				scl_lv = qtr_q[1];
				sda_lv = cnt_q[3] ? ~more : 1'b1;
			end
			default: begin
				scl_lv = 1'b1;
				sda_lv = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer.

	always_comb begin
		st_d    = st_q;
		div_d   = tick ? 6'h00 : div_q + 6'h01;
		qtr_d   = tick ? qtr_q + 2'h1 : qtr_q;
		cnt_d   = cnt_q;
		tx_d    = tx_q;
		rsh_d   = rsh_q;
		left_d  = left_q;
		sel_d   = sel_q;
		wdone_d = wdone_q;
		blk_d   = blk_q;
		wa_d    = wa_q;
		mode_d  = mode_q;
		rx_d    = rx_q;
		vld_d   = 1'b0;
		done_d  = 1'b0;
		nack_d  = nack_q;
		busy_d  = busy_q;
		if (tick && qtr_q == fmr_pkg::Q_SAMPLE) begin
			rsh_d = {rsh_q[6:0], bus.sda};
		end
		case (st_q)
			fmr_pkg::M_IDLE: begin
				div_d = 6'h00;
				qtr_d = 2'h0;
				if (go) begin
					st_d    = fmr_pkg::M_START;
					sel_d   = sel;
					blk_d   = blk;
					wa_d    = waddr;
					mode_d  = mode;
					left_d  = (nbyte == 8'h00) ? 8'h00 : nbyte - 8'h01;
					wdone_d = 1'b0;
					nack_d  = 1'b0;
					busy_d  = 1'b1;
				end
			end
			fmr_pkg::M_START: begin
				if (slot_end) begin
					st_d  = fmr_pkg::M_ADDR;
					cnt_d = fmr_pkg::BIT_NONE;
					tx_d  = {fmr_pkg::DEV_TYPE, blk_q, rw};
				end
			end
			fmr_pkg::M_ADDR, fmr_pkg::M_WADR: begin
				if (slot_end) begin
					if (cnt_q != fmr_pkg::BIT_LAST) begin
						cnt_d = cnt_q + fmr_pkg::BIT_ONE;
						tx_d  = {tx_q[6:0], 1'b0};
					end else if (rsh_q[0]) begin
						// The memory did not answer; give the bus back.
						nack_d = 1'b1;
						st_d   = fmr_pkg::M_STOP;
					end else if (st_q == fmr_pkg::M_WADR) begin
						wdone_d = 1'b1;
						st_d    = fmr_pkg::M_START;
					end else if (rw) begin
						st_d  = fmr_pkg::M_READ;
						cnt_d = fmr_pkg::BIT_NONE;
					end else begin
						st_d  = fmr_pkg::M_WADR;
						cnt_d = fmr_pkg::BIT_NONE;
						tx_d  = wa_q;
					end
				end
			end
			fmr_pkg::M_READ: begin
				if (slot_end) begin
					if (cnt_q == fmr_pkg::BIT_MSB) begin
						rx_d  = rsh_q;
						vld_d = 1'b1;
						cnt_d = fmr_pkg::BIT_LAST;
						if (!more && mode_q == fmr_pkg::END_STOP9) begin
							st_d = fmr_pkg::M_STOP;
						end else if (!more && mode_q == fmr_pkg::END_START9) begin
							st_d = fmr_pkg::M_RST;
						end
					end else if (cnt_q == fmr_pkg::BIT_LAST) begin
						cnt_d = fmr_pkg::BIT_NONE;
						if (more) begin
							left_d = left_q - 8'h01;
						end else if (mode_q == fmr_pkg::END_NACK_START) begin
							st_d = fmr_pkg::M_RST;
						end else begin
							st_d = fmr_pkg::M_STOP;
						end
					end else begin
						cnt_d = cnt_q + fmr_pkg::BIT_ONE;
					end
				end
			end
			fmr_pkg::M_RST: begin
				if (slot_end) begin
					st_d = fmr_pkg::M_STOP;
				end
			end
			fmr_pkg::M_STOP: begin
				if (slot_end) begin
					st_d   = fmr_pkg::M_IDLE;
					done_d = 1'b1;
					busy_d = 1'b0;
				end
			end
			default: begin
				st_d = fmr_pkg::M_IDLE;
			end
		endcase
	end

	// Registers; bus enables pull low, so they are the inverse of the wanted level.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q     <= fmr_pkg::M_IDLE;
			div_q    <= 6'h00;
			qtr_q    <= 2'h0;
			cnt_q    <= fmr_pkg::BIT_NONE;
			tx_q     <= 8'h00;
			rsh_q    <= 8'h00;
			left_q   <= 8'h00;
			sel_q    <= 1'b0;
			wdone_q  <= 1'b0;
			blk_q    <= 3'h0;
			wa_q     <= 8'h00;
			mode_q   <= fmr_pkg::END_NACK_STOP;
			rx_q     <= 8'h00;
			rx_vld_q <= 1'b0;
			done_q   <= 1'b0;
			nack_q   <= 1'b0;
			busy_q   <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			st_q     <= st_d;
			div_q    <= div_d;
			qtr_q    <= qtr_d;
			cnt_q    <= cnt_d;
			tx_q     <= tx_d;
			rsh_q    <= rsh_d;
			left_q   <= left_d;
			sel_q    <= sel_d;
			wdone_q  <= wdone_d;
			blk_q    <= blk_d;
			wa_q     <= wa_d;
			mode_q   <= mode_d;
			rx_q     <= rx_d;
			rx_vld_q <= vld_d;
			done_q   <= done_d;
			nack_q   <= nack_d;
			busy_q   <= busy_d;
			scl_oe_q <= ~scl_lv;
			sda_oe_q <= ~sda_lv;
		end
	end

	assign bus.scl_o    = 1'b0;
	assign bus.scl_oe   = scl_oe_q;
	assign bus.sda_m_o  = 1'b0;
	assign bus.sda_m_oe = sda_oe_q;

endmodule : fmr_mst
`default_nettype wire

/* sim/fmr_properties.sv */
// Concurrent checks on the joined two-wire bus and the memory end's status.
// Assumes the testbench instantiates it beside the interface, on the same clock and reset.
`timescale 1ns/100ps
`default_nettype none
module fmr_props (
	// Clock and reset.
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	// Bus wires and device enable.
	input  wire logic                        scl,
	input  wire logic                        sda,
	input  wire logic                        sda_d_oe,
	// Memory end status.
	input  wire logic [fmr_pkg::ADDR_W-1:0]  mem_addr_q,
	input  wire logic                        rd_stb_q,
	input  wire logic                        reading_q
);
	localparam int BYTE_CYC = 9 * 4 * fmr_pkg::QTR_CYC;
	logic [10:0] f_addr_q;
	logic [10:0] f_addr_d;
	logic [15:0] gap_q;
	logic [15:0] gap_d;
	logic [15:0] run_q;
	logic [15:0] run_d;
	logic [15:0] step_q;
	logic [15:0] step_d;

	////////////////////////////////////////////////////////////////////////////////
	// Fetched address, cycles since last fetch, length of a drive outside a read.
	// The step wait counts from a fetch until the latch moves past it; an ended read
	// clears it, since an aborted byte legally never steps.
	always_comb begin
		f_addr_d = rd_stb_q ? mem_addr_q : f_addr_q;
		if (rd_stb_q) begin
			step_d = 16'h0001;
		end else if (step_q == 16'h0000 || !reading_q || mem_addr_q == f_addr_q + 11'h001) begin
			step_d = 16'h0000;
		end else begin
			step_d = step_q + 16'h0001;
		end
		gap_d    = !reading_q ? 16'h0000 : (rd_stb_q ? 16'h0001 : gap_q + 16'h0001);
		run_d    = (sda_d_oe && !reading_q) ? run_q + 16'h0001 : 16'h0000;
	end
	// Registers only; a fresh reset clears the counts so no stale gap is judged.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			f_addr_q <= 11'h000;
			gap_q    <= 16'h0000;
			run_q    <= 16'h0000;
			step_q   <= 16'h0000;
		end else begin
			f_addr_q <= f_addr_d;
			gap_q    <= gap_d;
			run_q    <= run_d;
			step_q   <= step_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// One clock domain, so clocking and reset are given once.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_change_scl_low: assert property ($changed(sda_d_oe) |-> !scl)
		else $error("device drive changed while clock high");
	a_addr_step: assert property (step_q <= 16'(BYTE_CYC))
		else $error("address did not step after a fetch");
	a_stop_ends: assert property ((scl && $rose(sda)) |-> ##[1:6] !reading_q)
		else $error("read survived a stop");
	a_start_ends: assert property ((scl && $fell(sda)) |-> ##[1:6] !reading_q)
		else $error("read survived a start");
	a_fetch_scl_low: assert property (rd_stb_q |-> !scl)
		else $error("fetch outside clock low");
	a_read_fetches: assert property ($rose(reading_q) |-> ##[0:200] rd_stb_q)
		else $error("read began without a fetch");
	a_ack_short: assert property (run_q <= 16'd140)
		else $error("device held bus outside a read");
	a_byte_nine_clk: assert property ((rd_stb_q && gap_q > 16'h0200) |-> gap_q == 16'(BYTE_CYC))
		else $error("fetch spacing is not nine clocks");

	// Main scenarios seen.
	c_top_fetch: cover property (rd_stb_q && mem_addr_q == 11'h7FF);
	c_stop_read: cover property (scl && $rose(sda) && reading_q);
	c_start_read: cover property (scl && $fell(sda) && reading_q);

endmodule : fmr_props
`default_nettype wire

/* sim/i2c_memory_read_path_test.sv */
// Self-checking bench: master end and memory end joined, byte store modelled here.
// Assumes the design package and interface are compiled first.
`timescale 1ns/100ps
`default_nettype none
module i2c_memory_read_path_test;
	logic                sys_clk;
	logic                rst;
	logic                go;
	logic                sel;
	logic [2:0]          blk;
	logic [7:0]          waddr;
	logic [7:0]          nbyte;
	fmr_pkg::fmr_end_t   mode;
	logic                busy_q;
	logic [7:0]          rx_q;
	logic                rx_vld_q;
	logic                done_q;
	logic                nack_q;
	logic [10:0]         mem_addr_q;
	logic                rd_stb_q;
	logic [7:0]          mem_data;
	logic                reading_q;
	int                  fails;
	int                  num_checks;
	int                  cycles;

	////////////////////////////////////////////////////////////////////////////////
	// Store contents differ per block, so a wrong block shows as a wrong byte.
	function automatic logic [7:0] byte_of(input logic [10:0] a);
		return a[7:0] ^ {a[10:8], 5'h00};
	endfunction : byte_of
	assign mem_data = byte_of(mem_addr_q);

	fmr_if fmr_if_i ();
	fmr_dev fmr_dev_i (.sys_clk(sys_clk), .rst(rst), .bus(fmr_if_i), .mem_addr_q(mem_addr_q),
		.rd_stb_q(rd_stb_q), .mem_data(mem_data), .reading_q(reading_q));
	fmr_mst fmr_mst_i (.sys_clk(sys_clk), .rst(rst), .bus(fmr_if_i), .go(go), .sel(sel),
		.blk(blk), .waddr(waddr), .nbyte(nbyte), .mode(mode), .busy_q(busy_q), .rx_q(rx_q),
		.rx_vld_q(rx_vld_q), .done_q(done_q), .nack_q(nack_q));
	fmr_props fmr_props_i (.sys_clk(sys_clk), .rst(rst), .scl(fmr_if_i.scl),
		.sda(fmr_if_i.sda), .sda_d_oe(fmr_if_i.sda_d_oe), .mem_addr_q(mem_addr_q),
		.rd_stb_q(rd_stb_q), .reading_q(reading_q));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard; four reads need about 20000 cycles.
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			give_verdict();
		end
	end

	task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
			fails++;
		end
	endtask : check

	task automatic give_verdict();
		if (fails == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	// One request, every byte judged against the address it must come from.
	task automatic do_read(input logic s, input logic [2:0] b, input logic [7:0] w,
		input logic [7:0] n, input fmr_pkg::fmr_end_t m, input logic [10:0] a0);
		int k;
		int t;
		logic [10:0] a;
		@(negedge sys_clk);
		go = 1'b1;
		sel = s;
		blk = b;
		waddr = w;
		nbyte = n;
		mode = m;
		@(negedge sys_clk);
		go = 1'b0;
		check("busy after go", 11'h001, {10'h000, busy_q});
		a = a0;
		k = 0;
		t = 0;
		while (done_q !== 1'b1 && t < 20000) begin
			@(negedge sys_clk);
			t++;
			if (rx_vld_q === 1'b1) begin
				check("read byte", {3'h0, byte_of(a)}, {3'h0, rx_q});
				a = a + 11'h001;
				k++;
			end
		end
		check("request done", 11'h001, {10'h000, done_q});
		check("busy at end", 11'h000, {10'h000, busy_q});
		check("byte count", {3'h0, n}, 11'(k));
		check("address refused", 11'h000, {10'h000, nack_q});
		check("latch after read", a, mem_addr_q);
		repeat (10) @(negedge sys_clk);
		check("device drive", 11'h000, {10'h000, fmr_if_i.sda_d_oe});
		check("read status", 11'h000, {10'h000, reading_q});
	endtask : do_read

	////////////////////////////////////////////////////////////////////////////////
	// Write address, word address, repeated start, three bytes, no-ack and stop.
	task automatic sel_read();
		do_read(1'b1, 3'h3, 8'h10, 8'h03, fmr_pkg::END_NACK_STOP, 11'h310);
	endtask : sel_read

	// Current read in another block keeps the latch low byte, no-ack then start.
	task automatic cur_read();
		do_read(1'b0, 3'h5, 8'h00, 8'h02, fmr_pkg::END_NACK_START, 11'h513);
	endtask : cur_read

	// Read across the top location, ended by a stop in the acknowledge slot.
	task automatic wrap_read();
		do_read(1'b1, 3'h7, 8'hFE, 8'h03, fmr_pkg::END_STOP9, 11'h7FE);
	endtask : wrap_read

	// Single byte after the wrap, ended by a start in the acknowledge slot.
	task automatic start9_read();
		do_read(1'b0, 3'h0, 8'h00, 8'h01, fmr_pkg::END_START9, 11'h001);
	endtask : start9_read

	////////////////////////////////////////////////////////////////////////////////
	// Reset for three cycles, then each scenario in turn.
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		go = 1'b0;
		sel = 1'b0;
		blk = 3'h0;
		waddr = 8'h00;
		nbyte = 8'h00;
		mode = fmr_pkg::END_NACK_STOP;
		fails = 0;
		num_checks = 0;
		cycles = 0;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		check("latch at reset", 11'h000, mem_addr_q);
		sel_read();
		cur_read();
		wrap_read();
		start9_read();
		give_verdict();
	end

endmodule : i2c_memory_read_path_test
`default_nettype wire
